/* File: design/amd_pkg.sv */
/*
  Package for the alarm mask and output divider register bank: register
  indices, field positions, reset values and the packed carrier types.
  Assumes a 32-bit APB bus with one register per aligned word.
*/
package amd_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_ALARM_IRQ_MASK     = 8'h18;
  localparam logic [7:0] IDX_HS_DIV_OUT1_DIV_HI = 8'h19;
  localparam logic [7:0] IDX_OUT1_DIV_MID       = 8'h1a;
  localparam logic [7:0] IDX_OUT1_DIV_LO        = 8'h1b;
  localparam logic [7:0] IDX_OUT2_DIV_HI        = 8'h1c;
  localparam logic [7:0] IDX_OUT2_DIV_MID       = 8'h1d;
  localparam logic [7:0] IDX_OUT2_DIV_LO        = 8'h1e;
  localparam logic [7:0] IDX_OUT3_DIV_HI        = 8'h1f;
  localparam logic [7:0] IDX_IRQ_PIN_CTRL       = 8'h20;
  localparam logic [7:0] IDX_EVENT_STATUS       = 8'h21;
  localparam logic [7:0] IDX_EVENT_ENABLE       = 8'h22;
  localparam logic [7:0] IDX_ALARM_FLAGS        = 8'h23;

  // Byte address is index times four
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned ADDR_W   = 10;

  // Mask register layout
  localparam int unsigned MSK_UNLOCK_BIT  = 0;
  localparam int unsigned MSK_FOS_LSB     = 1;
  localparam int unsigned MSK_ALIGN_BIT   = 5;
  localparam logic [7:0]  MSK_WRITE_MASK  = 8'h3f;
  localparam logic [7:0]  MSK_RESET       = 8'h3f;

  // High-speed divider code and upper nibble layout
  localparam int unsigned HS_CODE_LSB     = 5;
  localparam int unsigned HS_CODE_W       = 3;
  localparam logic [2:0]  HS_CODE_MIN     = 3'h0;
  localparam logic [3:0]  HS_RATIO_BASE   = 4'h4;
  localparam logic [7:0]  HI_NIBBLE_MASK  = 8'h0f;
  localparam logic [7:0]  HS_HI_RESET     = 8'h00;
  localparam logic [7:0]  DIV_HI_RESET    = 8'h00;
  localparam logic [7:0]  DIV_MID_RESET   = 8'h00;
  localparam logic [7:0]  DIV_LO_RESET    = 8'h31;
  localparam int unsigned LS_DIV_W        = 20;

  // Interrupt pin control layout
  localparam int unsigned CTRL_PIN_EN_BIT = 0;
  localparam int unsigned CTRL_POL_BIT    = 1;
  localparam logic [7:0]  CTRL_WRITE_MASK = 8'h03;
  localparam logic [7:0]  CTRL_RESET      = 8'h02;

  // Sticky event layout
  localparam int unsigned EVT_PIN_RISE_BIT = 0;
  localparam int unsigned EVT_SKEW_IGN_BIT = 1;
  localparam int unsigned EVT_W            = 2;
  localparam logic [1:0]  EVT_RESET        = 2'h0;

  // Alarm flags as delivered by the alarm logic
  typedef struct packed {
    logic       frame_alignment_flag;
    logic [3:0] freq_offset_flag;
    logic       unlock_flag;
  } amd_alarm_type;

  // Divider settings handed to the clock path
  typedef struct packed {
    logic [2:0]  high_speed_output_divider;
    logic [3:0]  high_speed_ratio;
    logic [19:0] out1_low_speed_divider;
    logic [19:0] out2_low_speed_divider;
    logic [19:0] out3_low_speed_divider;
  } amd_div_type;

endpackage

/* File: design/amd_regs.sv */
/*
  Alarm interrupt mask and output divider register bank, with the interrupt
  pin logic and the coarse skew request gate.

  Register map, one byte per aligned word (byte address, contents):
    0x60  alarm mask: [5] alignment, [4:1] offset inputs 4..1, [0] unlock
    0x64  [7:5] high-speed divider code, [3:0] first divider bits 19:16
    0x68  first divider bits 15:8
    0x6c  first divider bits 7:0
    0x70  [3:0] second divider bits 19:16
    0x74  second divider bits 15:8
    0x78  second divider bits 7:0
    0x7c  [3:0] third divider bits 19:16
    0x80  pin control: [0] pin enable, [1] polarity, 1 is active high
    0x84  event status, write one to clear: [0] pin went active,
          [1] skew request thrown away
    0x88  event enable, same layout as the status
    0x8c  live alarm flags, read only, same layout as the mask
  Reserved bits and bus lanes 31:8 read as zero and ignore writes.

  Reset is synchronous and active low: mask 0x3f, code zero (ratio four),
  dividers 0x00031, 0x00031 and 0x00000, pin disabled with polarity high,
  events cleared and disabled.

  Bus timing:
    Zero wait states; pready follows psel and penable directly.
    Read data is captured at the setup edge and held until the next setup.
    Unmapped or misaligned accesses answer with pslverr and change nothing.
    A write with byte lane 0 disabled is dropped without an error.

  Interrupt pin:
    The pin state is registered, one cycle behind a flag or mask change.
    Polarity acts on the registered state, so it takes effect at once.

  Events and system interrupt:
    A sticky status bit and the interrupt rise at the same edge.
    A new event in the cycle of its clear wins, so no event is lost.

  Skew requests:
    The pin passes two flops; a rising edge gives one step pulse about
    three cycles later, or sets the thrown-away event at code zero.

  Outputs:
    Divider settings follow their registers combinationally; each byte
    takes effect alone, so software sees partial values while it writes.
    The pin, the step pulse and the interrupt come from flops.

  Assumes an APB master on core_clk_i, alarm flags from logic on the same
  clock, and an asynchronous skew increment pin that is synchronised here.
  Divider parity is software's duty and is not checked here; the low
  sixteen bits of the third divider are held outside this bank.
*/
// Implementation choice: the APB register port.
// What this block does
// R1 - Unmasked alignment flag drives interrupt when pin function enabled.
// R2 - Alignment mask set removes alignment flag from interrupt.
// R3 - Four frequency-offset masks each gate their own flag into interrupt.
// R4 - Unlock mask bit zero gates unlock flag into interrupt.
// R5 - Mask writes never alter the alarm flag values.
// R6 - Mask resets to 0x3f; bits 7:6 read zero.
// R7 - Three-bit high-speed code gives ratio code plus four.
// R8 - Skew increment requests are ignored while high-speed code is zero.
// R9 - First output divider built from registers 0x19, 0x1a, 0x1b.
// R10 - Second output divider built from registers 0x1c, 0x1d, 0x1e.
// R11 - Third divider upper nibble in 0x1f, reset zero, bits 7:4 read zero.
// R12 - Software programs each low-speed divider zero or odd.
// R13 - Low bytes reset to 0x31, middle bytes reset to zero.
// R14 - Polarity bit picks active low or high interrupt pin.
// R15 - Reserved bits read zero; interrupt is OR of unmasked flags.
module amd_regs (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [9:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  input  wire amd_pkg::amd_alarm_type alarm_flags_i,
  input  wire logic                  skew_inc_pin_i,
  output logic                       skew_step_o,
  output logic                       irq_alarm_pin_o,
  output logic                       irq_o,
  output amd_pkg::amd_div_type       div_cfg_o
);
  import amd_pkg::*;

  // Register storage
  logic [7:0]       mask_reg;
  logic [2:0]       hs_code_reg;
  logic [3:0]       out1_hi_reg;
  logic [7:0]       out1_mid_reg;
  logic [7:0]       out1_lo_reg;
  logic [3:0]       out2_hi_reg;
  logic [7:0]       out2_mid_reg;
  logic [7:0]       out2_lo_reg;
  logic [3:0]       out3_hi_reg;
  logic [7:0]       ctrl_reg;
  logic [EVT_W-1:0] evt_status_reg;
  logic [EVT_W-1:0] evt_status_next;
  logic [EVT_W-1:0] evt_enable_reg;
  logic [EVT_W-1:0] evt_set;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             pin_active_reg;
  logic             skew_meta_reg;
  logic             skew_sync_reg;
  logic             skew_prev_reg;
  logic             skew_step_reg;
  logic             irq_reg;

  // Decode and strobe signals
  logic [7:0]       reg_idx;
  logic             idx_ok;
  logic             setup_phase;
  logic             access_phase;
  logic             wr_en;
  logic [7:0]       wbyte;
  logic             alarm_any;
  logic             skew_rise;
  logic [3:0]       fos_masked;

  // Word index from the byte address; low two bits must be zero
  // Accesses outside the map are refused below, never aliased
  assign reg_idx      = paddr_i[ADDR_W-1:ADDR_LSB];
  assign idx_ok       = (paddr_i[ADDR_LSB-1:0] == 2'h0) &&
                        (reg_idx >= IDX_ALARM_IRQ_MASK) &&
                        (reg_idx <= IDX_ALARM_FLAGS);
  assign setup_phase  = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;
  // Only the low byte lane carries register data
  assign wr_en        = access_phase && pwrite_i && idx_ok && pstrb_i[0];
  assign wbyte        = pwdata_i[7:0];

  // Zero-wait slave: read data was captured at the setup edge
  // Trade-off: a flag change between setup and access is not seen,
  // in return for read data that comes straight from a flop
  assign pready_o  = access_phase;
  assign pslverr_o = access_phase && !idx_ok;
  assign prdata_o  = rdata_reg;

  // Mask register, only the six mask bits are writable
  // Reserved bits 7:6 are never stored, so they cannot read back
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      // R6 - mask reset value
      mask_reg <= MSK_RESET;
    end else if (wr_en && reg_idx == IDX_ALARM_IRQ_MASK) begin
      // R5 - flags untouched
      mask_reg <= wbyte & MSK_WRITE_MASK;
    end
  end

  // High-speed code and first output divider
  // Code and nibble share one word, so one write updates both
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hs_code_reg  <= HS_HI_RESET[HS_CODE_LSB +: HS_CODE_W];
      out1_hi_reg  <= HS_HI_RESET[3:0];
      // R13 - divider byte resets
      out1_mid_reg <= DIV_MID_RESET;
      out1_lo_reg  <= DIV_LO_RESET;
    end else if (wr_en) begin
      // R9 - first divider bytes
      if (reg_idx == IDX_HS_DIV_OUT1_DIV_HI) begin
        hs_code_reg <= wbyte[HS_CODE_LSB +: HS_CODE_W];
        out1_hi_reg <= wbyte[3:0];
      end
      if (reg_idx == IDX_OUT1_DIV_MID) begin
        out1_mid_reg <= wbyte;
      end
      if (reg_idx == IDX_OUT1_DIV_LO) begin
        out1_lo_reg <= wbyte;
      end
    end
  end

  // Second output divider
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      out2_hi_reg  <= DIV_HI_RESET[3:0];
      out2_mid_reg <= DIV_MID_RESET;
      out2_lo_reg  <= DIV_LO_RESET;
    end else if (wr_en) begin
      // R10 - second divider bytes
      if (reg_idx == IDX_OUT2_DIV_HI) begin
        out2_hi_reg <= wbyte[3:0];
      end
      if (reg_idx == IDX_OUT2_DIV_MID) begin
        out2_mid_reg <= wbyte;
      end
      if (reg_idx == IDX_OUT2_DIV_LO) begin
        out2_lo_reg <= wbyte;
      end
    end
  end

  // Third output divider upper nibble; its lower bytes live elsewhere
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      // R11 - nibble resets to zero
      out3_hi_reg <= DIV_HI_RESET[3:0];
    end else if (wr_en && reg_idx == IDX_OUT3_DIV_HI) begin
      out3_hi_reg <= wbyte[3:0];
    end
  end

  // Interrupt pin control: enable and polarity
  // Polarity resets high with the pin disabled, so the pin starts low
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_en && reg_idx == IDX_IRQ_PIN_CTRL) begin
      ctrl_reg <= wbyte & CTRL_WRITE_MASK;
    end
  end

  // Event enable for the system interrupt
  // Events start disabled so reset leaves the interrupt quiet
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      evt_enable_reg <= EVT_RESET;
    end else if (wr_en && reg_idx == IDX_EVENT_ENABLE) begin
      evt_enable_reg <= wbyte[EVT_W-1:0];
    end
  end

  // Divider outputs; odd or zero values are left to software
  // No staging: a divider changes byte by byte as software writes it
  always_comb begin
    // R7 - ratio is code plus four
    div_cfg_o.high_speed_output_divider = hs_code_reg;
    div_cfg_o.high_speed_ratio          = HS_RATIO_BASE + {1'b0, hs_code_reg};
    // R12 - relies on software values
    div_cfg_o.out1_low_speed_divider    = {out1_hi_reg, out1_mid_reg, out1_lo_reg};
    div_cfg_o.out2_low_speed_divider    = {out2_hi_reg, out2_mid_reg, out2_lo_reg};
    div_cfg_o.out3_low_speed_divider    = {out3_hi_reg, 16'h0000};
  end

  // R3 - per-input offset gating
  // One gate per input clock; a set mask bit keeps its flag out
  // of the interrupt but leaves the flag itself alone
  for (genvar g = 0; g < 4; g++) begin : g_fos_gate
    assign fos_masked[g] = alarm_flags_i.freq_offset_flag[g] &&
                           !mask_reg[MSK_FOS_LSB + g];
  end

  // Masked alarm combination; a set mask bit removes its flag
  always_comb begin
    // R15 - OR of unmasked flags
    alarm_any  = (|fos_masked) ||
                 // R1 - alignment flag gated
                 // R2 - alignment mask excludes
                 (alarm_flags_i.frame_alignment_flag && !mask_reg[MSK_ALIGN_BIT]) ||
                 // R4 - unlock flag gated
                 (alarm_flags_i.unlock_flag && !mask_reg[MSK_UNLOCK_BIT]);
  end

  // Pin state registered so the pin never glitches on flag changes
  // The cost is one cycle of latency on every alarm
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_active_reg <= 1'b0;
    end else begin
      pin_active_reg <= alarm_any && ctrl_reg[CTRL_PIN_EN_BIT];
    end
  end

  // R14 - polarity applied to pin
  assign irq_alarm_pin_o = ctrl_reg[CTRL_POL_BIT] ? pin_active_reg : !pin_active_reg;

  // Skew increment pin synchroniser, first stage read only by the second
  // The first stage may go metastable, so nothing else looks at it;
  // resetting all three low matches the idle pin and avoids a false edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      skew_meta_reg <= 1'b0;
      skew_sync_reg <= 1'b0;
      skew_prev_reg <= 1'b0;
    end else begin
      skew_meta_reg <= skew_inc_pin_i;
      skew_sync_reg <= skew_meta_reg;
      skew_prev_reg <= skew_sync_reg;
    end
  end

  // Rising edge of the synchronised pin is one skew request
  assign skew_rise = skew_sync_reg && !skew_prev_reg;

  // Skew step pulse to the output phase logic
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      skew_step_reg <= 1'b0;
    end else begin
      // R8 - ignore at code zero
      skew_step_reg <= skew_rise && (hs_code_reg != HS_CODE_MIN);
    end
  end

  // Registered pulse, so it stands for exactly one cycle
  assign skew_step_o = skew_step_reg;

  // Event sources: pin going active, and a skew request thrown away
  // The pin event fires in the cycle before the pin state turns active
  always_comb begin
    evt_set                   = '0;
    evt_set[EVT_PIN_RISE_BIT] = alarm_any && ctrl_reg[CTRL_PIN_EN_BIT] && !pin_active_reg;
    evt_set[EVT_SKEW_IGN_BIT] = skew_rise && (hs_code_reg == HS_CODE_MIN);
  end

  // Write one to clear; a new event in the clearing cycle still lands
  always_comb begin
    evt_status_next = evt_status_reg | evt_set;
    if (wr_en && reg_idx == IDX_EVENT_STATUS) begin
      evt_status_next = (evt_status_reg & ~wbyte[EVT_W-1:0]) | evt_set;
    end
  end

  // Sticky status flops
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      evt_status_reg <= EVT_RESET;
    end else begin
      evt_status_reg <= evt_status_next;
    end
  end

  // Level interrupt from enabled sticky events
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_status_next & evt_enable_reg);
    end
  end

  // Level output, low only once every enabled event is cleared
  assign irq_o = irq_reg;

  // Read mux; reserved bits and upper lanes read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_idx)
      IDX_ALARM_IRQ_MASK:     rdata_next[7:0] = mask_reg & MSK_WRITE_MASK;
      IDX_HS_DIV_OUT1_DIV_HI: rdata_next[7:0] = {hs_code_reg, 1'b0, out1_hi_reg};
      IDX_OUT1_DIV_MID:       rdata_next[7:0] = out1_mid_reg;
      IDX_OUT1_DIV_LO:        rdata_next[7:0] = out1_lo_reg;
      IDX_OUT2_DIV_HI:        rdata_next[7:0] = {4'h0, out2_hi_reg};
      IDX_OUT2_DIV_MID:       rdata_next[7:0] = out2_mid_reg;
      IDX_OUT2_DIV_LO:        rdata_next[7:0] = out2_lo_reg;
      // R11 - reserved nibble zero
      IDX_OUT3_DIV_HI:        rdata_next[7:0] = {4'h0, out3_hi_reg};
      IDX_IRQ_PIN_CTRL:       rdata_next[7:0] = ctrl_reg & CTRL_WRITE_MASK;
      IDX_EVENT_STATUS:       rdata_next[EVT_W-1:0] = evt_status_reg;
      IDX_EVENT_ENABLE:       rdata_next[EVT_W-1:0] = evt_enable_reg;
      IDX_ALARM_FLAGS:        rdata_next[5:0] = alarm_flags_i;
      default:                rdata_next = 32'h0000_0000;
    endcase
    if (!idx_ok) begin
      rdata_next = 32'h0000_0000;
    end
  end

  // Read data captured in the setup cycle so it comes from a flop
  // The mux follows the address, which the master holds from setup on,
  // so the captured word is the one the access phase will return
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (setup_phase) begin
      rdata_reg <= rdata_next;
    end
  end

endmodule

/* File: dv/amd_host_model.sv */
/*
  Host model: an APB master that software uses to reach the register bank.
  Assumes the bench calls xfer one transfer at a time, all on core_clk_i.
*/
module amd_host_model (
  input  wire logic        core_clk_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [9:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  output logic [3:0]       pstrb_o,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdata;
  logic        rerr;

  // Idle bus from time zero; all byte lanes enabled until a transfer sets its own strobes
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 10'h000;
    pwdata_o  = 32'h0000_0000;
    pstrb_o   = 4'hf;
  end

  // One transfer, held until pready is sampled high; the bench timeout cuts a hang
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge core_clk_i);
    psel_o    <= 1'b1;
    pstrb_o   <= s;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    do @(posedge core_clk_i); while (pready_i !== 1'b1);
    rdata = prdata_i;
    rerr  = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

/* File: dv/amd_regs_properties.sv */
/*
  Checker for the register bank, watching only the top module's ports.
  Assumes one clock and the synchronous active-low reset; bound below.
*/
module amd_regs_properties
  import amd_pkg::*;
(
  input wire logic         core_clk_i,
  input wire logic         rst_n_i,
  input wire logic         psel_i,
  input wire logic         penable_i,
  input wire logic         pwrite_i,
  input wire logic [9:0]   paddr_i,
  input wire logic [31:0]  pwdata_i,
  input wire logic [3:0]   pstrb_i,
  input wire logic [31:0]  prdata_o,
  input wire logic         pslverr_o,
  input wire logic         skew_step_o,
  input wire amd_div_type  div_cfg_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic acc_wr;

  // Write access with byte lane 0 enabled; the address is matched where it is used
  assign acc_wr = psel_i && penable_i && pwrite_i && pstrb_i[0];

  a_hs_ratio_sum: assert property (
    div_cfg_o.high_speed_ratio == {1'b0, div_cfg_o.high_speed_output_divider} + 4'h4)
    else $error("ratio is not code plus four");
  a_skew_gate_zero: assert property (
    skew_step_o |-> $past(div_cfg_o.high_speed_output_divider) != 3'h0)
    else $error("skew step while code is zero");
  a_skew_one_pulse: assert property (skew_step_o |=> !skew_step_o)
    else $error("skew step longer than one cycle");
  a_out3_low_zero: assert property (
    div_cfg_o.out3_low_speed_divider[15:0] == 16'h0000)
    else $error("third divider low bits not zero");
  a_read_upper_zero: assert property (
    psel_i && penable_i && !pwrite_i |-> prdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_misalign_error: assert property (
    psel_i && penable_i && paddr_i[1:0] != 2'b00 |-> pslverr_o)
    else $error("misaligned access without error");
  a_out1_lo_write: assert property (
    acc_wr && paddr_i == {IDX_OUT1_DIV_LO, 2'b00}
    |=> div_cfg_o.out1_low_speed_divider[7:0] == $past(pwdata_i[7:0]))
    else $error("first divider low byte not written");
  a_out2_mid_write: assert property (
    acc_wr && paddr_i == {IDX_OUT2_DIV_MID, 2'b00}
    |=> div_cfg_o.out2_low_speed_divider[15:8] == $past(pwdata_i[7:0]))
    else $error("second divider middle byte not written");
  a_reset_dividers: assert property ($rose(rst_n_i) |->
    div_cfg_o.out1_low_speed_divider == 20'h0_0031
    && div_cfg_o.out2_low_speed_divider == 20'h0_0031)
    else $error("divider reset value wrong");
endmodule

bind amd_regs amd_regs_properties u_props (.core_clk_i, .rst_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pslverr_o, .skew_step_o, .div_cfg_o);

/* File: dv/amd_regs_bench.sv */
/*
  Self-checking bench for the register bank: APB tasks via the host model.
  Assumes the design package and the checker bind are compiled beforehand.
*/
module amd_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import amd_pkg::*;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        skew_pin, skew_step, irq_pin, irq;
  logic [3:0]  pstrb;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  flags;
  amd_div_type div_cfg;
  int          num_errors, checks_done, cycles, n;
  logic [7:0]  rst_val [8] = '{8'h3f, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h31, 8'h00};

  amd_regs dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .alarm_flags_i(flags), .skew_inc_pin_i(skew_pin),
    .skew_step_o(skew_step), .irq_alarm_pin_o(irq_pin), .irq_o(irq), .div_cfg_o(div_cfg));
  amd_host_model host (.core_clk_i(core_clk), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
    .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Run is some hundreds of cycles; the ceiling leaves wide margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, 4'hf);
    check(host.rdata, e);
  endtask
  // Lets registered outputs land before they are looked at
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // Pin held high three cycles, then low; count step pulses
  task automatic skew_pulse(input int exp);
    n = 0;
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      skew_pin <= (i < 3);
      @(negedge core_clk);
      n += int'(skew_step === 1'b1);
    end
    check(32'(n), 32'(exp));
  endtask

  initial begin
    rst_n    = 1'b0;
    flags    = 6'h00;
    skew_pin = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(10'h060 + 10'(4 * i), 32'(rst_val[i]));
    // Reserved bits ignore writes
    wr(10'h060, 32'h0000_00ff);
    rd(10'h060, 32'h0000_003f);
    wr(10'h07c, 32'h0000_00ff);
    rd(10'h07c, 32'h0000_000f);
    for (int c = 0; c < 8; c++) begin
      wr(10'h064, 32'({3'(c), 5'h10}));
      settle();
      check(32'(div_cfg.high_speed_ratio), 32'(c + 4));
      check(32'(div_cfg.high_speed_output_divider), 32'(c));
      rd(10'h064, 32'({3'(c), 5'h00}));
    end
    wr(10'h064, 32'h0000_0025);
    wr(10'h068, 32'h0000_0023);
    wr(10'h06c, 32'h0000_0047);
    wr(10'h070, 32'h0000_000a);
    wr(10'h074, 32'h0000_00bc);
    wr(10'h078, 32'h0000_00d9);
    settle();
    check(32'(div_cfg.out1_low_speed_divider), 32'h0005_2347);
    check(32'(div_cfg.out2_low_speed_divider), 32'h000a_bcd9);
    // Third divider: only its nibble is held here, low bits come from elsewhere
    check(32'(div_cfg.out3_low_speed_divider), 32'h000f_0000);
    // Pin enabled, active high, every flag alone through its mask
    wr(10'h080, 32'h0000_0003);
    @(posedge core_clk);
    flags <= 6'h3f;
    settle();
    check(32'(irq_pin), 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      flags <= 6'h01 << i;
      wr(10'h060, 32'(8'h3f & ~(8'h01 << i)));
      settle();
      check(32'(irq_pin), 32'h0000_0001);
      rd(10'h08c, 32'(8'h01 << i));
      wr(10'h060, 32'h0000_003f);
      settle();
      check(32'(irq_pin), 32'h0000_0000);
    end
    // Event interrupt raised, masked, cleared
    @(posedge core_clk);
    flags <= 6'h00;
    wr(10'h088, 32'h0000_0001);
    settle();
    check(32'(irq), 32'h0000_0001);
    wr(10'h088, 32'h0000_0000);
    settle();
    check(32'(irq), 32'h0000_0000);
    wr(10'h088, 32'h0000_0001);
    wr(10'h084, 32'h0000_0001);
    settle();
    check(32'(irq), 32'h0000_0000);
    rd(10'h084, 32'h0000_0000);
    // Active-low pin
    wr(10'h080, 32'h0000_0001);
    settle();
    check(32'(irq_pin), 32'h0000_0001);
    @(posedge core_clk);
    flags <= 6'h01;
    wr(10'h060, 32'h0000_003e);
    settle();
    check(32'(irq_pin), 32'h0000_0000);
    skew_pulse(1);
    wr(10'h064, 32'h0000_0005);
    skew_pulse(0);
    rd(10'h084, 32'h0000_0003);
    // Unmapped and misaligned places answer with an error
    rd(10'h090, 32'h0000_0000);
    check(32'(host.rerr), 32'h0000_0001);
    wr(10'h061, 32'h0000_0000);
    check(32'(host.rerr), 32'h0000_0001);
    rd(10'h060, 32'h0000_003e);
    // Byte lane 0 disabled: dropped without an error
    host.xfer(1'b1, 10'h060, 32'h0000_0000, 4'he);
    check(32'(host.rerr), 32'h0000_0000);
    rd(10'h060, 32'h0000_003e);
    finish_test();
  end
endmodule
